/* core/cpsr_pkg.sv */
// Shared constants and carrier types for the slow register file,
// high-address byte file and operand byte buffer.
// Assumes one microcycle clock and decoded microinstruction strobes.
package cpsr_pkg;

	// Storage geometry
	localparam int DATA_W     = 16;
	localparam int SLOW_DEPTH = 256;
	localparam int HI_DEPTH   = 16;
	localparam int HI_W       = 8;
	localparam int XBUF_DEPTH = 2;

	// Buffer state pointer encodings
	localparam logic [1:0] PTR_EMPTY = 2'h0;
	localparam logic [1:0] PTR_BYTE  = 2'h1;
	localparam logic [1:0] PTR_FULL  = 2'h2;
	localparam logic [1:0] PTR_WORD  = 2'h3;

	// Click phase on which the opcode dispatch is honoured
	localparam logic [1:0] PHASE_C2 = 2'h2;

	// Function-select pattern that frees the Z field for input selects
	localparam logic [1:0] FS_IOX = 2'h3;

	// Input-select codes of the Z field during a slow register access
	localparam logic [3:0] FZ_IOX_HI_BYTE = 4'h1;
	localparam logic [3:0] FZ_IOX_ADV     = 4'h2;
	localparam logic [3:0] FZ_IOX_HOLD    = 4'h3;
	localparam logic [3:0] FZ_IOX_UPPER   = 4'h4;
	localparam logic [3:0] FZ_IOX_LOWER   = 4'h5;
	localparam logic [3:0] FZ_IOX_STATE   = 4'h6;

	// Reset values
	localparam logic [7:0] HEAD_RESET = 8'h00;
	localparam logic [3:0] NIB_RESET  = 4'h0;

	typedef struct packed {
		logic [3:0] func_select_field;
		logic [3:0] port_a_sel;
		logic [3:0] port_b_sel;
		logic [3:0] func_field_z;
	} cpsr_fields_t;

	typedef struct packed {
		logic hi_byte_write;
		logic hi_byte_read;
		logic mem_addr_load;
		logic read_head_advance;
		logic read_head_hold;
		logic read_head_upper_nibble;
		logic read_head_lower_nibble;
		logic opcode_dispatch;
		logic forced_opcode_dispatch;
		logic buffer_load;
		logic select_even_head;
		logic select_odd_head;
		logic read_state_complement;
	} cpsr_fn_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
	} cpsr_xword_t;

endpackage

/* core/cpsr_fifo.sv */
// Small first-in first-out buffer held in flip-flops.
// Assumes both sides run on mclk; depth and width are parameters.
`timescale 1ns/1ps
`default_nettype none
module cpsr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Draining side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL_CNT);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_idx];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_idx] <= in_data;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
			if (pop)
				rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* core/cpsr_core.sv */
// Slow register file, high-address byte file and operand byte buffer
// of the microprogrammed processor, with its X bus source path.
// Assumes decoded strobes from the microinstruction decoder, all on mclk,
// and a datapath that drains X bus words through a ready handshake.
// Functional notes
// - 256x16 slow file, Y writes, X reads
// - Normal mode address is port A, Z
// - Stack mode uses 0,,stack pointer before modification
// - Indirect mode uses previous Y low nibble
// - Function select 3 decodes Z input selects
// - 16x8 high byte file by port B
// - High byte write from X low, read zeroed
// - Upper address bus driven every cycle
// - Three-byte FIFO; head read or dispatched
// - Dispatch in C2 decrements pointer, reloads head
// - Non-full plain dispatch traps, forced never; interrupt trap first
// - Fewer than three bytes traps to refill
// - Even, odd, head registers; 2-bit pointer codes
// - Advancing read gray-decrements and refills head
// - Hold and nibble reads keep the pointer
// - Load fills even, odd; head when empty
// - Load with odd select takes odd byte
// - Load with advancing read keeps the buffer; head still read
// - Even or odd select alone reloads head
// - State complement read onto two X bits
`timescale 1ns/1ps
`default_nettype none
module cpsr_core
	import cpsr_pkg::*;
#(
	parameter int SLOW_WORDS = cpsr_pkg::SLOW_DEPTH,
	parameter int HI_WORDS   = cpsr_pkg::HI_DEPTH,
	parameter int XBUF_WORDS = cpsr_pkg::XBUF_DEPTH
) (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// Microinstruction fields and controls
	input  wire cpsr_pkg::cpsr_fields_t fields,
	input  wire cpsr_pkg::cpsr_fn_t     fn,
	input  wire logic [1:0]            click_phase,
	input  wire logic                  slow_reg_enable,
	input  wire logic                  carry_in,
	input  wire logic                  indirect_addr_fn,
	input  wire logic [3:0]            stack_pointer,
	input  wire logic                  pending_interrupt_flag,
	// Data buses
	input  wire logic [15:0]           y_bus,
	input  wire logic [15:0]           x_bus,
	// X bus source handshake
	output logic                       x_rd_room,
	output logic                       x_rd_valid,
	output cpsr_pkg::cpsr_xword_t      x_rd_data,
	input  wire logic                  x_rd_ready,
	// Memory address extension
	output logic [7:0]                 upper_addr_bus,
	// Dispatch and traps
	output logic                       dispatch_valid,
	output logic [7:0]                 dispatch_target,
	output logic                       refill_trap,
	output logic                       interrupt_trap,
	output logic [1:0]                 buffer_state_ptr
);
	// Storage
	logic [15:0] slow_regs [SLOW_WORDS];
	logic [7:0]  high_addr_byte_file [HI_WORDS];
	logic [7:0]  even_byte;
	logic [7:0]  odd_byte;
	logic [7:0]  head_byte_reg;
	logic [1:0]  ptr;

	// Indirect addressing memory of the previous instruction
	logic        prev_indirect;
	logic [3:0]  prev_y_nib;

	// Decode
	logic        normal_mode;
	logic        iox_active;
	logic [7:0]  slow_addr;
	logic        slow_read;
	logic        slow_write;
	logic        rd_hi;
	logic        rd_adv;
	logic        rd_hold;
	logic        rd_upper;
	logic        rd_lower;
	logic        rd_state;
	logic        x_req;
	cpsr_xword_t x_word;
	logic        do_load;
	logic        do_advance;
	logic        do_dispatch;

	// Buffer next state
	logic [1:0]  next_ptr;
	logic [7:0]  next_head;
	logic        load_pair;

	function automatic logic [1:0] gray_dec(input logic [1:0] p);
		logic [1:0] r;
		r = PTR_FULL;
		unique case (p)
			PTR_FULL:  r = PTR_WORD;
			PTR_WORD:  r = PTR_BYTE;
			PTR_BYTE:  r = PTR_EMPTY;
			PTR_EMPTY: r = PTR_FULL;
		endcase
		return r;
	endfunction

	// Field bit 1 of the select is the second bit from the bottom
	assign normal_mode = fields.func_select_field[1];
	assign slow_read   = slow_reg_enable && !carry_in;
	assign slow_write  = slow_reg_enable && carry_in;
	assign iox_active  = slow_reg_enable &&
		(fields.func_select_field[1:0] == FS_IOX);

	always_comb
	begin
		if (!normal_mode)
			slow_addr = {4'h0, stack_pointer};
		else if (prev_indirect)
			slow_addr = {fields.port_a_sel, prev_y_nib};
		else
			slow_addr = {fields.port_a_sel, fields.func_field_z};
	end

	// Z field doubles as an input select while the slow file is in use
	assign rd_hi    = fn.hi_byte_read ||
		(iox_active && fields.func_field_z == FZ_IOX_HI_BYTE);
	assign rd_adv   = fn.read_head_advance ||
		(iox_active && fields.func_field_z == FZ_IOX_ADV);
	assign rd_hold  = fn.read_head_hold ||
		(iox_active && fields.func_field_z == FZ_IOX_HOLD);
	assign rd_upper = fn.read_head_upper_nibble ||
		(iox_active && fields.func_field_z == FZ_IOX_UPPER);
	assign rd_lower = fn.read_head_lower_nibble ||
		(iox_active && fields.func_field_z == FZ_IOX_LOWER);
	assign rd_state = fn.read_state_complement ||
		(iox_active && fields.func_field_z == FZ_IOX_STATE);

	// X bus source selection; only one source is expected per cycle
	always_comb
	begin
		x_req       = 1'b1;
		x_word.data = 16'h0000;
		if (slow_read)
			x_word.data = slow_regs[slow_addr];
		else if (rd_hi)
			x_word.data = {8'h00, high_addr_byte_file[fields.port_b_sel]};
		else if (rd_adv || rd_hold)
			x_word.data = {8'h00, head_byte_reg};
		else if (rd_upper)
			x_word.data = {12'h000, head_byte_reg[7:4]};
		else if (rd_lower)
			x_word.data = {12'h000, head_byte_reg[3:0]};
		else if (rd_state)
			x_word.data = {12'h000, ~ptr, 2'b00};
		else
			x_req = 1'b0;
	end

	// A full output buffer stalls the advance so no byte is lost
	cpsr_fifo #(
		.WIDTH ($bits(cpsr_xword_t)),
		.DEPTH (XBUF_WORDS)
	) u_xbuf (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (x_req),
		.in_data   (x_word),
		.in_ready  (x_rd_room),
		.out_valid (x_rd_valid),
		.out_data  (x_rd_data),
		.out_ready (x_rd_ready)
	);

	// Read and write of the buffer together cancel each other
	assign do_load     = fn.buffer_load && !rd_adv;
	assign do_advance  = rd_adv && !fn.buffer_load && x_rd_room;
	assign do_dispatch = (fn.opcode_dispatch || fn.forced_opcode_dispatch)
		&& (click_phase == PHASE_C2);

	always_comb
	begin
		next_ptr  = ptr;
		next_head = head_byte_reg;
		load_pair = 1'b0;
		if (do_load)
		begin
			load_pair = 1'b1;
			if (ptr == PTR_EMPTY && fn.select_odd_head)
			begin
				next_head = x_bus[7:0];
				next_ptr  = PTR_BYTE;
			end
			else if (ptr == PTR_EMPTY)
			begin
				next_head = x_bus[15:8];
				next_ptr  = PTR_WORD;
			end
			else
				next_ptr = PTR_FULL;
		end
		else if (do_advance || do_dispatch)
		begin
			next_ptr  = gray_dec(ptr);
			next_head = ptr[1] ? odd_byte : even_byte;
		end
		else if (fn.select_even_head)
		begin
			next_head = even_byte;
			next_ptr  = PTR_WORD;
		end
		else if (fn.select_odd_head)
		begin
			next_head = odd_byte;
			next_ptr  = PTR_BYTE;
		end
	end

	// Storage arrays carry no reset; software initialises them
	always_ff @(posedge mclk)
	begin
		if (slow_write)
			slow_regs[slow_addr] <= y_bus;
	end

	// Loads during an address load are excluded by microcode
	always_ff @(posedge mclk)
	begin
		if (fn.hi_byte_write)
			high_addr_byte_file[fields.port_b_sel] <= x_bus[7:0];
	end

	assign upper_addr_bus = high_addr_byte_file[fields.port_b_sel];

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_indirect <= 1'b0;
			prev_y_nib    <= NIB_RESET;
		end
		else
		begin
			prev_indirect <= indirect_addr_fn;
			prev_y_nib    <= y_bus[3:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr           <= PTR_EMPTY;
			head_byte_reg <= HEAD_RESET;
			even_byte     <= HEAD_RESET;
			odd_byte      <= HEAD_RESET;
		end
		else
		begin
			ptr           <= next_ptr;
			head_byte_reg <= next_head;
			if (load_pair)
			begin
				even_byte <= x_bus[15:8];
				odd_byte  <= x_bus[7:0];
			end
		end
	end

	assign buffer_state_ptr = ptr;

	// Dispatch result is registered, one cycle after the request
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dispatch_valid  <= 1'b0;
			dispatch_target <= HEAD_RESET;
			refill_trap     <= 1'b0;
			interrupt_trap  <= 1'b0;
		end
		else
		begin
			dispatch_valid <= do_dispatch;
			if (do_dispatch)
				dispatch_target <= head_byte_reg;
			// The forced form never traps
			refill_trap <= do_dispatch && fn.opcode_dispatch &&
				ptr != PTR_FULL && !pending_interrupt_flag;
			interrupt_trap <= do_dispatch && fn.opcode_dispatch &&
				ptr != PTR_FULL && pending_interrupt_flag;
		end
	end
endmodule
`default_nettype wire

/* sim/cpsr_core_props.sv */
// Assertions on the buffer pointer, dispatch, traps and high byte file.
// Assumes it is bound to cpsr_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cpsr_core_props
	import cpsr_pkg::*;
(
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   rst_n,
	// Controls
	input wire cpsr_pkg::cpsr_fields_t fields,
	input wire cpsr_pkg::cpsr_fn_t     fn,
	input wire logic [1:0]             click_phase,
	input wire logic                   pending_interrupt_flag,
	input wire logic                   slow_reg_enable,
	input wire logic [15:0]            x_bus,
	// Results
	input wire logic [7:0]             upper_addr_bus,
	input wire logic                   dispatch_valid,
	input wire logic                   refill_trap,
	input wire logic                   interrupt_trap,
	input wire logic [1:0]             buffer_state_ptr
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic disp;
	logic load;
	logic full;
	logic adv;
	// An advancing read also arrives through the Z input select
	assign adv  = fn.read_head_advance || (slow_reg_enable
		&& fields.func_select_field[1:0] == FS_IOX
		&& fields.func_field_z == FZ_IOX_ADV);
	// Loads outrank a dispatch and advancing reads share its step, so leave them out
	assign disp = (fn.opcode_dispatch | fn.forced_opcode_dispatch)
		&& click_phase == PHASE_C2 && !fn.buffer_load
		&& !adv;
	assign load = fn.buffer_load && !adv;
	assign full = buffer_state_ptr == PTR_FULL;
	a_disp_pulse:
		assert property (disp |=> dispatch_valid)
		else $error("dispatch answer missing");
	a_disp_gray:
		assert property (disp |=> buffer_state_ptr == {
			~$past(buffer_state_ptr[0]), $past(buffer_state_ptr[1])})
		else $error("dispatch pointer step wrong");
	a_refill_trap:
		assert property (disp && fn.opcode_dispatch && !full
			&& !pending_interrupt_flag |=> refill_trap && !interrupt_trap)
		else $error("refill trap missing");
	a_int_first:
		assert property (disp && fn.opcode_dispatch && !full
			&& pending_interrupt_flag |=> interrupt_trap && !refill_trap)
		else $error("interrupt trap not preferred");
	a_full_quiet:
		assert property (disp && full |=> !refill_trap && !interrupt_trap)
		else $error("trap on full buffer");
	a_load_empty:
		assert property (load && buffer_state_ptr == PTR_EMPTY
			|=> buffer_state_ptr == ($past(fn.select_odd_head)
			? PTR_BYTE : PTR_WORD))
		else $error("load into empty buffer wrong");
	a_load_more:
		assert property (load && buffer_state_ptr != PTR_EMPTY |=> full)
		else $error("load did not fill buffer");
	a_load_adv:
		assert property (fn.buffer_load && adv
			|=> $stable(buffer_state_ptr))
		else $error("load with advance changed pointer");
	a_hi_write:
		assert property (fn.hi_byte_write ##1 !fn.hi_byte_write
			&& $stable(fields.port_b_sel)
			|-> upper_addr_bus == $past(x_bus[7:0]))
		else $error("upper address byte wrong");
	c_refill: cover property (refill_trap);
	c_int: cover property (interrupt_trap);
	c_disp: cover property (disp ##1 disp);
endmodule
bind cpsr_core cpsr_core_props u_props (
	.mclk(mclk), .rst_n(rst_n), .fields(fields), .fn(fn),
	.click_phase(click_phase),
	.pending_interrupt_flag(pending_interrupt_flag),
	.slow_reg_enable(slow_reg_enable),
	.x_bus(x_bus), .upper_addr_bus(upper_addr_bus),
	.dispatch_valid(dispatch_valid), .refill_trap(refill_trap),
	.interrupt_trap(interrupt_trap), .buffer_state_ptr(buffer_state_ptr)
);
`default_nettype wire

/* sim/cpsr_dpath_model.sv */
// Model of the datapath that drains X bus words from the block.
// Assumes the bench steers stall; ready follows it at once.
`timescale 1ns/1ps
`default_nettype none
module cpsr_dpath_model
	import cpsr_pkg::*;
(
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// Test control
	input  wire logic                  stall,
	// Word stream from the block
	input  wire logic                  x_rd_valid,
	input  wire cpsr_pkg::cpsr_xword_t x_rd_data,
	output logic                       x_rd_ready,
	output logic [15:0]                got
);
	// Ready only drops on command, so a stalled word is always held
	assign x_rd_ready = !stall;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			got <= 16'h0000;
		else if (x_rd_valid && x_rd_ready)
			got <= x_rd_data.data;
	end
endmodule
`default_nettype wire

/* sim/cp_slow_regs_and_operand_buffer_bench.sv */
// Self-checking bench for slow registers, high bytes and operand buffer.
// Assumes the package, core, checker and datapath model compile first.
`timescale 1ns/1ps
`default_nettype none
module cp_slow_regs_and_operand_buffer_bench;
	import cpsr_pkg::*;
	localparam cpsr_fn_t f_nop = 13'h0000;
	localparam cpsr_fn_t f_hw = 13'h1000;
	localparam cpsr_fn_t f_hr = 13'h0800;
	localparam cpsr_fn_t f_adv = 13'h0200;
	localparam cpsr_fn_t f_hold = 13'h0100;
	localparam cpsr_fn_t f_up = 13'h0080;
	localparam cpsr_fn_t f_lo = 13'h0040;
	localparam cpsr_fn_t f_dsp = 13'h0020;
	localparam cpsr_fn_t f_fdsp = 13'h0010;
	localparam cpsr_fn_t f_ld = 13'h0008;
	localparam cpsr_fn_t f_se = 13'h0004;
	localparam cpsr_fn_t f_so = 13'h0002;
	localparam cpsr_fn_t f_st = 13'h0001;
	logic         mclk = 1'h0;
	logic         rst_n = 1'h0;
	cpsr_fields_t fields = '0;
	cpsr_fn_t     fn = '0;
	logic [1:0]   phase = 2'h2;
	logic         sre = 1'h0;
	logic         cin = 1'h0;
	logic         ind = 1'h0;
	logic [3:0]   sp = 4'h0;
	logic         pend = 1'h0;
	logic [15:0]  y = 16'h0000;
	logic [15:0]  x = 16'h0000;
	logic         stall = 1'h0;
	logic         room, valid, ready, dv, rf, it;
	cpsr_xword_t  xd;
	logic [7:0]   upper, tgt;
	logic [1:0]   ptr;
	logic [15:0]  got;
	int           failures = 0;
	int           comparisons = 0;
	wire logic [15:0] dview = {dv, rf, it, 3'h0, ptr, tgt};
	always #2.5 mclk = ~mclk;
	cpsr_core dut (
		.mclk(mclk), .rst_n(rst_n), .fields(fields), .fn(fn),
		.click_phase(phase), .slow_reg_enable(sre), .carry_in(cin),
		.indirect_addr_fn(ind), .stack_pointer(sp),
		.pending_interrupt_flag(pend), .y_bus(y), .x_bus(x),
		.x_rd_room(room), .x_rd_valid(valid), .x_rd_data(xd),
		.x_rd_ready(ready), .upper_addr_bus(upper),
		.dispatch_valid(dv), .dispatch_target(tgt), .refill_trap(rf),
		.interrupt_trap(it), .buffer_state_ptr(ptr)
	);
	cpsr_dpath_model model (
		.mclk(mclk), .rst_n(rst_n), .stall(stall), .x_rd_valid(valid),
		.x_rd_data(xd), .x_rd_ready(ready), .got(got)
	);
	task automatic op(input cpsr_fn_t f, input logic [15:0] xv,
		input logic [1:0] s);
		fn = f;
		x = xv;
		{sre, cin} = s;
		@(negedge mclk);
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// One cycle to issue, one for the datapath to take the word
	task automatic rd(input cpsr_fn_t f, input logic [1:0] s,
		input logic [15:0] e);
		op(f, 16'h0000, s);
		op(f_nop, 16'h0000, 2'h0);
		chk("x word", e, got);
	endtask
	task automatic tend(input string n);
		$display("test %s done", n);
	endtask
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge mclk);
		failures++;
		test_done;
	end
	initial
	begin
		repeat (20) @(negedge mclk);
		rst_n = 1'h1;
		chk("ptr", 16'h0000, ptr);
		op(f_ld, 16'habcd, 2'h0);
		chk("ptr", 16'h0003, ptr);
		rd(f_hold, 2'h0, 16'h00ab);
		rd(f_up, 2'h0, 16'h000a);
		rd(f_lo, 2'h0, 16'h000b);
		chk("ptr", 16'h0003, ptr);
		rd(f_adv, 2'h0, 16'h00ab);
		rd(f_hold, 2'h0, 16'h00cd);
		rd(f_st, 2'h0, 16'h0008);
		chk("ptr", 16'h0001, ptr);
		tend("reads");
		op(f_ld, 16'h1234, 2'h0);
		op(f_dsp, 16'h0000, 2'h0);
		chk("disp", 16'h83cd, dview);
		pend = 1'h1;
		op(f_dsp, 16'h0000, 2'h0);
		chk("disp", 16'ha134, dview);
		pend = 1'h0;
		op(f_dsp, 16'h0000, 2'h0);
		chk("disp", 16'hc034, dview);
		op(f_fdsp, 16'h0000, 2'h0);
		chk("disp", 16'h8212, dview);
		phase = 2'h1;
		op(f_dsp, 16'h0000, 2'h0);
		chk("disp", 16'h0212, dview);
		phase = 2'h2;
		tend("dispatch");
		rd(f_ld | f_adv, 2'h0, 16'h0012);
		chk("ptr", 16'h0002, ptr);
		op(f_se, 16'h0000, 2'h0);
		chk("ptr", 16'h0003, ptr);
		rd(f_hold, 2'h0, 16'h0012);
		op(f_so, 16'h0000, 2'h0);
		rd(f_hold, 2'h0, 16'h0034);
		rd(f_adv, 2'h0, 16'h0034);
		chk("ptr", 16'h0000, ptr);
		op(f_ld | f_so, 16'h5678, 2'h0);
		rd(f_hold, 2'h0, 16'h0078);
		chk("ptr", 16'h0001, ptr);
		tend("loads");
		fields = {4'h2, 4'h5, 4'h7, 4'h6};
		op(f_hw, 16'h00a5, 2'h0);
		chk("upper", 16'h00a5, upper);
		rd(f_hr, 2'h0, 16'h00a5);
		fields.port_b_sel = 4'h2;
		op(f_hw, 16'h003c, 2'h0);
		chk("upper", 16'h003c, upper);
		fields.port_b_sel = 4'h7;
		rd(f_hr, 2'h0, 16'h00a5);
		// Writes and reads of the slow file never share a cycle
		y = 16'hbeef;
		op(f_nop, 16'h0000, 2'h3);
		fields.func_select_field = 4'h0;
		sp = 4'h3;
		y = 16'h1111;
		op(f_nop, 16'h0000, 2'h3);
		rd(f_nop, 2'h2, 16'h1111);
		fields.func_select_field = 4'h2;
		rd(f_nop, 2'h2, 16'hbeef);
		ind = 1'h1;
		y = 16'h0006;
		fields.func_field_z = 4'h9;
		op(f_nop, 16'h0000, 2'h0);
		ind = 1'h0;
		rd(f_nop, 2'h2, 16'hbeef);
		fields = {4'h3, 4'h5, 4'h7, 4'h3};
		y = 16'h2222;
		rd(f_nop, 2'h3, 16'h0078);
		fields.func_field_z = FZ_IOX_HI_BYTE;
		rd(f_nop, 2'h3, 16'h00a5);
		fields.func_select_field = 4'h2;
		rd(f_nop, 2'h2, 16'h2222);
		tend("files");
		stall = 1'h1;
		op(f_hold, 16'h0000, 2'h0);
		op(f_up, 16'h0000, 2'h0);
		chk("room", 16'h0000, room);
		op(f_adv, 16'h0000, 2'h0);
		chk("ptr", 16'h0001, ptr);
		stall = 1'h0;
		op(f_nop, 16'h0000, 2'h0);
		chk("x word", 16'h0078, got);
		op(f_nop, 16'h0000, 2'h0);
		chk("x word", 16'h0007, got);
		chk("valid", 16'h0000, valid);
		tend("stall");
		test_done;
	end
endmodule
`default_nettype wire
